// [rtl/btram_defines.svh]
// Constants of the byte-wide timekeeping RAM
`ifndef BTRAM_DEFINES_SVH
`define BTRAM_DEFINES_SVH
`define BTRAM_ADDR_W 11
`define BTRAM_OFF_CTRL 3'h0
`define BTRAM_OFF_SEC 3'h1
`define BTRAM_OFF_MIN 3'h2
`define BTRAM_OFF_HOUR 3'h3
`define BTRAM_OFF_DAY 3'h4
`define BTRAM_OFF_DATE 3'h5
`define BTRAM_OFF_MONTH 3'h6
`define BTRAM_OFF_YEAR 3'h7
`define BTRAM_BIT_WRITE 7
`define BTRAM_BIT_READ 6
`define BTRAM_BIT_HALT 7
`define BTRAM_BIT_FTEST 6
`define BTRAM_CLK_HZ 50000000
`define BTRAM_TEST_HZ 512
`define BTRAM_TEST_HALF ((`BTRAM_CLK_HZ / `BTRAM_TEST_HZ) / 2)
`define BTRAM_TICKS_SEC (`BTRAM_TEST_HZ * 2)
`define BTRAM_RESET_DATE 8'h01
`endif

// [rtl/btram_pkg.sv]
// Types of the byte-wide timekeeping RAM
`default_nettype none
package btram_pkg;
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } btram_time_s;
endpackage
`default_nettype wire

// [rtl/btram_top.sv]
// Byte-wide RAM with a BCD calendar clock in its top eight bytes
`timescale 1ns/100ps
`default_nettype none
`include "btram_defines.svh"
module btram_top #(
   parameter int ADDR_W = `BTRAM_ADDR_W,
   parameter int TEST_HALF = `BTRAM_TEST_HALF
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // SRAM-style host pins, asynchronous to SYS_CLK
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic SELECT_N,
   input wire logic OUT_DRIVE_N,
   input wire logic WRITE_N,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE_N,
   // Supply monitor
   input wire logic POWER_FAIL
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [ADDR_W+11:0] sync1;
   logic [ADDR_W+11:0] sync2;
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sync1 <= '1;
         sync2 <= '1;
      end else begin
         sync1 <= {ADDR, SELECT_N, OUT_DRIVE_N, WRITE_N, POWER_FAIL, DATA_IN};
         sync2 <= sync1;
      end
   end
   wire [ADDR_W-1:0] s_addr = sync2[ADDR_W+11:12];
   wire s_sel_n = sync2[11];
   wire s_oe_n = sync2[10];
   wire s_we_n = sync2[9];
   wire s_pfail = sync2[8];
   wire [7:0] s_din = sync2[7:0];

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   wire selected = !s_sel_n && !s_pfail;
   wire wr_active = selected && !s_we_n;
   logic wr_prev;
   wire wr_start = wr_active && !wr_prev;
   wire rd_drive = selected && s_we_n && !s_oe_n;
   wire is_clk = &s_addr[ADDR_W-1:3];
   wire [2:0] reg_off = s_addr[2:0];

   // ----------------------------------------------------------------
   // Storage and user registers
   // ----------------------------------------------------------------
   logic [7:0] mem [0:(1<<ADDR_W)-1];
   logic [7:0] ctrl;
   btram_pkg::btram_time_s user;
   btram_pkg::btram_time_s cnt;
   logic osc_halt;
   logic ftest;
   logic test_bit;
   wire halted = ctrl[`BTRAM_BIT_READ] || ctrl[`BTRAM_BIT_WRITE];
   wire wr_clk = wr_start && is_clk;
   wire wr_ctrl = wr_clk && reg_off == `BTRAM_OFF_CTRL;
   wire write_release = wr_ctrl && ctrl[`BTRAM_BIT_WRITE] && !s_din[`BTRAM_BIT_WRITE];

   always_ff @(posedge SYS_CLK) begin
      if (wr_start && !is_clk) begin
         mem[s_addr] <= s_din;
      end
   end
   property p_mem_write;
      @(posedge SYS_CLK) disable iff (!RESETN) (wr_start && !is_clk) |=> mem[$past(s_addr)] == $past(s_din);
   endproperty
   a_mem_write: assert property (p_mem_write) else $error("RAM byte not stored");

   // ----------------------------------------------------------------
   // Timebase: 512 Hz toggle and one-second tick
   // ----------------------------------------------------------------
   logic [$clog2(TEST_HALF+1)-1:0] div;
   logic [10:0] ticks;
   wire tick = !osc_halt && div == TEST_HALF[$clog2(TEST_HALF+1)-1:0] - 1'b1;
   wire sec_tick = tick && ticks == 11'(`BTRAM_TICKS_SEC - 1);
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         div <= '0;
         ticks <= '0;
         test_bit <= 1'b0;
      end else if (!osc_halt) begin
         div <= tick ? '0 : div + 1'b1;
         if (tick) begin
            ticks <= sec_tick ? 11'h000 : ticks + 11'h001;
            test_bit <= !test_bit;
         end
      end
   end
   property p_toggle;
      @(posedge SYS_CLK) disable iff (!RESETN) tick |=> test_bit != $past(test_bit);
   endproperty
   a_toggle: assert property (p_toggle) else $error("test toggle missed");

   // ----------------------------------------------------------------
   // BCD counting helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction
   function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      leap = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                   : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8));
      unique case (m)
         8'h02: month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default: month_days = 8'h31;
      endcase
   endfunction

   btram_pkg::btram_time_s next_cnt;
   always_comb begin
      next_cnt = cnt;
      if (sec_tick) begin
         next_cnt.sec = bcd_inc(cnt.sec);
         if (cnt.sec == 8'h59) begin
            next_cnt.sec = 8'h00;
            next_cnt.min = bcd_inc(cnt.min);
            if (cnt.min == 8'h59) begin
               next_cnt.min = 8'h00;
               next_cnt.hour = bcd_inc(cnt.hour);
               if (cnt.hour == 8'h23) begin
                  next_cnt.hour = 8'h00;
                  next_cnt.day = (cnt.day == 8'h07) ? 8'h01 : bcd_inc(cnt.day);
                  next_cnt.date = bcd_inc(cnt.date);
                  if (cnt.date == month_days(cnt.month, cnt.year)) begin
                     next_cnt.date = `BTRAM_RESET_DATE;
                     next_cnt.month = bcd_inc(cnt.month);
                     if (cnt.month == 8'h12) begin
                        next_cnt.month = 8'h01;
                        next_cnt.year = (cnt.year == 8'h99) ? 8'h00 : bcd_inc(cnt.year);
                     end
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt <= '{year: 8'h00, month: 8'h01, date: 8'h01, day: 8'h01,
                  hour: 8'h00, min: 8'h00, sec: 8'h00};
      end else if (write_release) begin
         cnt <= user;
      end else begin
         cnt <= next_cnt;
      end
   end
   // Divider keeps running across a load, so the first second may be short
   property p_load;
      @(posedge SYS_CLK) disable iff (!RESETN) write_release |=> cnt == $past(user);
   endproperty
   a_load: assert property (p_load) else $error("counters not loaded");
   property p_osc_stop;
      @(posedge SYS_CLK) disable iff (!RESETN) osc_halt |=> $stable(cnt) || $past(write_release);
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("counting while stopped");
   property p_hour_range;
      @(posedge SYS_CLK) disable iff (!RESETN) cnt.hour == 8'h23 && cnt.min == 8'h59
         && cnt.sec == 8'h59 && sec_tick && !write_release |=> cnt.hour == 8'h00;
   endproperty
   a_hour_range: assert property (p_hour_range) else $error("hour past 23");
   property p_feb;
      @(posedge SYS_CLK) disable iff (!RESETN) cnt.month == 8'h02 && cnt.year == 8'h23
         |-> cnt.date != 8'h29;
   endproperty
   a_feb: assert property (p_feb) else $error("leap day in common year");
   property p_leap_day;
      @(posedge SYS_CLK) disable iff (!RESETN) cnt.year == 8'h24 && cnt.month == 8'h02
         && cnt.date == 8'h28 && cnt.hour == 8'h23 && cnt.min == 8'h59 && cnt.sec == 8'h59
         && sec_tick && !write_release |=> cnt.date == 8'h29;
   endproperty
   a_leap_day: assert property (p_leap_day) else $error("leap day skipped");

   // ----------------------------------------------------------------
   // User copy and control bits
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl <= 8'h00;
         user <= '{year: 8'h00, month: 8'h01, date: 8'h01, day: 8'h01,
                   hour: 8'h00, min: 8'h00, sec: 8'h00};
         osc_halt <= 1'b0;
         ftest <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= {s_din[7:6], 6'h00};
         end
         if (wr_clk && reg_off == `BTRAM_OFF_SEC) begin
            osc_halt <= s_din[`BTRAM_BIT_HALT];
         end
         if (wr_clk && reg_off == `BTRAM_OFF_DAY) begin
            ftest <= s_din[`BTRAM_BIT_FTEST];
         end
         if (wr_clk && ctrl[`BTRAM_BIT_WRITE]) begin
            unique case (reg_off)
               `BTRAM_OFF_SEC: user.sec <= {1'b0, s_din[6:0]};
               `BTRAM_OFF_MIN: user.min <= {1'b0, s_din[6:0]};
               `BTRAM_OFF_HOUR: user.hour <= {2'b00, s_din[5:0]};
               `BTRAM_OFF_DAY: user.day <= {5'h00, s_din[2:0]};
               `BTRAM_OFF_DATE: user.date <= {2'b00, s_din[5:0]};
               `BTRAM_OFF_MONTH: user.month <= {3'h0, s_din[4:0]};
               `BTRAM_OFF_YEAR: user.year <= s_din;
               default: ;
            endcase
         end else if (!halted && !wr_ctrl) begin
            user <= cnt;
         end
      end
   end
   property p_read_hold;
      @(posedge SYS_CLK) disable iff (!RESETN)
         (ctrl[`BTRAM_BIT_READ] && !wr_clk) |=> $stable(user);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("user moved while halted");
   property p_track;
      @(posedge SYS_CLK) disable iff (!RESETN)
         (!halted && !wr_ctrl) |=> user == $past(cnt);
   endproperty
   a_track: assert property (p_track) else $error("user not tracking");

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_prev <= 1'b0;
      end else begin
         wr_prev <= wr_active;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [7:0] clk_byte;
   always_comb begin
      unique case (reg_off)
         `BTRAM_OFF_CTRL: clk_byte = ctrl;
         `BTRAM_OFF_SEC: clk_byte = {osc_halt, user.sec[6:1],
                                     (ftest && !osc_halt) ? test_bit : user.sec[0]};
         `BTRAM_OFF_MIN: clk_byte = user.min;
         `BTRAM_OFF_HOUR: clk_byte = user.hour;
         `BTRAM_OFF_DAY: clk_byte = {1'b0, ftest, user.day[5:0]};
         `BTRAM_OFF_DATE: clk_byte = user.date;
         `BTRAM_OFF_MONTH: clk_byte = user.month;
         default: clk_byte = user.year;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         DATA_OUT <= 8'h00;
         DATA_OE_N <= 1'b1;
      end else begin
         DATA_OUT <= is_clk ? clk_byte : mem[s_addr];
         DATA_OE_N <= !rd_drive;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_pfail_float;
      @(posedge SYS_CLK) disable iff (!RESETN) s_pfail |=> DATA_OE_N;
   endproperty
   a_pfail_float: assert property (p_pfail_float) else $error("driven in power fail");
   property p_read_drive;
      @(posedge SYS_CLK) disable iff (!RESETN) rd_drive |=> !DATA_OE_N;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read not driven");
   property p_deselect;
      @(posedge SYS_CLK) disable iff (!RESETN) !rd_drive |=> DATA_OE_N;
   endproperty
   a_deselect: assert property (p_deselect) else $error("driven outside a read");
endmodule // btram_top
`default_nettype wire

// [testbench/btram_host.sv]
// Host bus master model for the timekeeping RAM pins
`timescale 1ns/100ps
`default_nettype none
module btram_host (
   // Clock
   input wire logic clk,
   // SRAM-style pins
   output logic [10:0] addr,
   output logic select_n,
   output logic out_drive_n,
   output logic write_n,
   output logic [7:0] data_in,
   // Read side
   input wire logic [7:0] data_out,
   input wire logic data_oe_n
);
   // ----------
   // Bus cycles
   // ----------
   initial begin
      addr = 11'h000;
      select_n = 1'b1;
      out_drive_n = 1'b1;
      write_n = 1'b1;
      data_in = 8'h00;
   end
   // Strobes held four cycles, since the pins pass two sync flops
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      data_in = d;
      select_n = 1'b0;
      write_n = 1'b0;
      repeat (4) @(negedge clk);
      select_n = 1'b1;
      write_n = 1'b1;
      data_in = ~d;
      repeat (3) @(negedge clk);
   endtask
   task automatic rd(input logic [10:0] a, input logic od_n, output logic [7:0] d,
                     output logic oe_n);
      @(negedge clk);
      addr = a;
      select_n = 1'b0;
      out_drive_n = od_n;
      repeat (4) @(negedge clk);
      d = data_out;
      oe_n = data_oe_n;
      select_n = 1'b1;
      out_drive_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask
   // Seconds read held steady while data line zero is watched
   task automatic watch(output int flips);
      logic last;
      flips = 0;
      @(negedge clk);
      addr = 11'h7F9;
      select_n = 1'b0;
      out_drive_n = 1'b0;
      repeat (4) @(negedge clk);
      last = data_out[0];
      repeat (32) begin
         @(negedge clk);
         flips += int'(data_out[0] !== last);
         last = data_out[0];
      end
      select_n = 1'b1;
      out_drive_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask
endmodule // btram_host
`default_nettype wire

// [testbench/btram_top_bench.sv]
// Self-checking bench for the byte-wide timekeeping RAM
`timescale 1ns/100ps
`default_nettype none
module btram_top_bench;
   // Short half period keeps one second at 4096 cycles
   localparam int TH = 4;
   localparam int SEC = TH * 1024;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic power_fail = 1'b0;
   logic [10:0] addr;
   logic select_n, out_drive_n, write_n, data_oe_n, oe;
   logic [7:0] data_in, data_out, d, s0;
   int miscompares = 0;
   int checks = 0;
   int n;
   btram_pkg::btram_time_s start [6] = '{56'h23_02_28_07_23_59_59, 56'h24_02_28_07_23_59_59,
      56'h24_02_29_07_23_59_59, 56'h00_02_28_07_23_59_59, 56'h23_04_30_07_23_59_59,
      56'h99_12_31_07_23_59_59};
   btram_pkg::btram_time_s finish [6] = '{56'h23_03_01_01_00_00_00, 56'h24_02_29_01_00_00_00,
      56'h24_03_01_01_00_00_00, 56'h00_02_29_01_00_00_00, 56'h23_05_01_01_00_00_00,
      56'h00_01_01_01_00_00_00};
   always #10 sys_clk = ~sys_clk;
   btram_top #(.ADDR_W(11), .TEST_HALF(TH)) u_dut (.SYS_CLK(sys_clk), .RESETN(resetn),
      .ADDR(addr), .SELECT_N(select_n), .OUT_DRIVE_N(out_drive_n), .WRITE_N(write_n),
      .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n),
      .POWER_FAIL(power_fail));
   btram_host u_host (.clk(sys_clk), .addr(addr), .select_n(select_n),
      .out_drive_n(out_drive_n), .write_n(write_n), .data_in(data_in),
      .data_out(data_out), .data_oe_n(data_oe_n));
   // -------------
   // Check helpers
   // -------------
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic chk(input logic [2:0] off, input logic [7:0] exp);
      u_host.rd({8'hFF, off}, 1'b0, d, oe);
      cmp_bit(oe, 1'b0);
      cmp_byte(d, exp);
   endtask
   task automatic chk_all(input btram_pkg::btram_time_s t);
      for (int i = 1; i < 8; i++) begin
         chk(3'(i), t[8*(i-1) +: 8]);
      end
   endtask
   // Write-halt brackets the load so the counters take all fields at once
   task automatic load(input btram_pkg::btram_time_s t);
      u_host.wr(11'h7F8, 8'h80);
      for (int i = 1; i < 8; i++) begin
         u_host.wr({8'hFF, 3'(i)}, t[8*(i-1) +: 8]);
      end
      u_host.wr(11'h7F8, 8'h00);
   endtask
   task automatic stop_test;
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Polls seconds until it leaves 59, bounded to just over one second
   task automatic wait_roll;
      n = 0;
      do begin
         u_host.rd(11'h7F9, 1'b0, d, oe);
         n++;
      end while (d === 8'h59 && n < 600);
      if (n >= 600) begin
         miscompares++;
         stop_test();
      end
   endtask
   // ---------
   // Scenarios
   // ---------
   initial begin
      repeat (4) @(negedge sys_clk);
      resetn = 1'b1;
      chk(3'h0, 8'h00);
      chk_all(56'h00_01_01_01_00_00_00);
      u_host.wr(11'h000, 8'hA5);
      u_host.wr(11'h7F7, 8'h3C);
      chk(3'h0, 8'h00);
      u_host.rd(11'h000, 1'b0, d, oe);
      cmp_byte(d, 8'hA5);
      u_host.rd(11'h7F7, 1'b1, d, oe);
      cmp_bit(oe, 1'b1);
      power_fail = 1'b1;
      u_host.wr(11'h7F7, 8'h00);
      u_host.rd(11'h7F7, 1'b0, d, oe);
      cmp_bit(oe, 1'b1);
      power_fail = 1'b0;
      u_host.rd(11'h7F7, 1'b0, d, oe);
      cmp_byte(d, 8'h3C);
      for (int i = 0; i < 6; i++) begin
         load(start[i]);
         wait_roll();
         u_host.wr(11'h7F8, 8'h40);
         chk_all(finish[i]);
         u_host.wr(11'h7F8, 8'h00);
      end
      u_host.wr(11'h7F8, 8'h40);
      u_host.rd(11'h7F9, 1'b0, s0, oe);
      repeat (SEC + SEC / 2) @(negedge sys_clk);
      chk(3'h1, s0);
      chk(3'h0, 8'h40);
      u_host.wr(11'h7F8, 8'h00);
      repeat (SEC) @(negedge sys_clk);
      u_host.rd(11'h7F9, 1'b0, d, oe);
      cmp_bit(d >= s0 + 8'h02 && d <= s0 + 8'h03, 1'b1);
      load(56'h23_03_01_01_00_00_80);
      repeat (SEC + SEC / 2) @(negedge sys_clk);
      chk(3'h1, 8'h80);
      load(56'h23_03_01_41_00_00_00);
      chk(3'h4, 8'h41);
      u_host.watch(n);
      cmp_byte(8'(n), 8'h08);
      stop_test();
   end
endmodule // btram_top_bench
`default_nettype wire
